// ---- rtl/cntarr_pkg.sv ----
package cntarr_pkg;

  // ------------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] CTRL_STATUS_OFS = 8'hD8;
  localparam logic [7:0] COUNTER_OFS = 8'h00;
  localparam logic [7:0] CNT_MODE_OFS = 8'h04;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h0C;
  localparam logic [7:0] MODE_BASE_OFS = 8'h20;
  localparam logic [7:0] CMP_LOW_BASE_OFS = 8'h40;
  localparam logic [7:0] CMP_RELOAD_BASE_OFS = 8'h60;
  localparam int MODULE_STRIDE = 4;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int CS_OVF_BIT = 7;
  localparam int CS_RUN_BIT = 6;
  localparam int CS_RSVD_BIT = 5;
  localparam int COUNTER_MODE_REG_OVF_IE_BIT = 0;
  localparam int MODE_FLAG_IE_BIT = 0;
  localparam int MODE_PWM_BIT = 1;
  localparam int MODE_TOG_BIT = 2;
  localparam int MODE_MATCH_BIT = 3;
  localparam int MODE_CMP_BIT = 6;
  localparam int IRQ_OVF_BIT = 5;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] CTRL_STATUS_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [15:0] COUNTER_RST = 16'h0000;
  localparam logic [7:0] CMP_RST = 8'h00;
  localparam logic [7:0] LOW_BYTE_MAX = 8'hFF;

  // Per-module output mode
  typedef enum logic [1:0] {CNTARR_OFF, CNTARR_TOGGLE, CNTARR_PWM} cntarr_mode_t;

  // APB request carrier
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [7:0] addr;
    logic [31:0] wdata;
  } cntarr_apb_req_t;

endpackage : cntarr_pkg

// ---- rtl/cntarr_top.sv ----
// Function
// RULE_01 - Toggle mode inverts pin on compare match
// RULE_02 - Toggle mode needs toggle, match, comparator
// RULE_03 - All PWM modules share one counter
// RULE_04 - Duty set per module by low compare
// RULE_05 - PWM low below compare, high otherwise
// RULE_06 - Low byte wrap reloads low compare
// RULE_07 - PWM mode needs PWM and comparator
// RULE_08 - Match sets flag, enabled flag interrupts
// RULE_09 - Flags cleared only by software zero write
// RULE_10 - Control layout: overflow, run, reserved, flags
// RULE_11 - Control register resets to zero
// RULE_12 - Overflow sets flag, optional interrupt
// RULE_13 - Counter runs only while run set
`timescale 1ns/1ps
module cntarr_top
  import cntarr_pkg::*;
#(
  parameter int NUM_MODULES = 5
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  output logic [NUM_MODULES-1:0] MODULE_OUTPUT_PIN_O,
  output logic COUNTER_ARRAY_IRQ_O,
  output logic IRQ_O
);

  // ------------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------------
  cntarr_apb_req_t req;
  logic wr_en;
  logic rd_en;
  logic [7:0] mod_ofs;
  logic [2:0] mod_idx;
  logic mod_hit;
  assign req = '{sel: PSEL_I, enable: PENABLE_I, write: PWRITE_I,
                 addr: PADDR_I, wdata: PWDATA_I};
  assign wr_en = req.sel && req.enable && req.write;
  assign rd_en = req.sel && req.enable && !req.write;
  assign mod_ofs = req.addr & 8'h1F;
  assign mod_idx = 3'(mod_ofs >> 2);
  assign mod_hit = (req.addr[1:0] == 2'h0) && (32'(mod_idx) < NUM_MODULES);
  // Zero wait state slave
  assign PREADY_O = 1'b1;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  logic [15:0] counter, next_counter;
  logic run, next_run;
  logic ovf_flag, next_ovf_flag;
  logic [NUM_MODULES-1:0] ev_flag, next_ev_flag;
  logic [7:0] cnt_mode, next_cnt_mode;
  logic [7:0] mode_reg [NUM_MODULES];
  logic [7:0] next_mode_reg [NUM_MODULES];
  logic [7:0] cmp_low [NUM_MODULES];
  logic [7:0] next_cmp_low [NUM_MODULES];
  logic [7:0] cmp_rel [NUM_MODULES];
  logic [7:0] next_cmp_rel [NUM_MODULES];
  logic [NUM_MODULES-1:0] pin, next_pin;
  logic [5:0] irq_stat, next_irq_stat;
  logic [5:0] irq_mask, next_irq_mask;
  logic [31:0] next_prdata;
  logic next_slverr;
  logic [NUM_MODULES-1:0] match;
  logic wrap;
  cntarr_mode_t mode_sel [NUM_MODULES];
  logic [NUM_MODULES-1:0] flag_ie;
  logic slverr_q;
  logic [31:0] next_rd_word;
  logic next_rd_err;

  // Counter advances only while running; wrap of low byte is the reload point
  assign wrap = run && (counter[7:0] == LOW_BYTE_MAX); // [RULE_06]

  // ------------------------------------------------------------------
  // Per-module compare logic
  // ------------------------------------------------------------------
  generate
    for (genvar m = 0; m < NUM_MODULES; m++) begin : g_mod
      logic [7:0] cm;
      assign cm = mode_reg[m];
      assign flag_ie[m] = cm[MODE_FLAG_IE_BIT]; // [RULE_08]
      // Decode mode; PWM wins if software sets both
      always_comb begin
        if (cm[MODE_CMP_BIT] && cm[MODE_PWM_BIT]) begin // [RULE_07]
          mode_sel[m] = CNTARR_PWM;
        end else if (cm[MODE_CMP_BIT] && cm[MODE_TOG_BIT] && cm[MODE_MATCH_BIT]) begin // [RULE_02]
          mode_sel[m] = CNTARR_TOGGLE;
        end else begin
          mode_sel[m] = CNTARR_OFF;
        end
      end
      // Match on full counter, evaluated only on a counting edge
      assign match[m] = run && cm[MODE_CMP_BIT] &&
                        (counter == {cmp_rel[m], cmp_low[m]}); // [RULE_01]
      // Next pin, compare and reload values
      always_comb begin
        next_pin[m] = pin[m];
        next_cmp_low[m] = cmp_low[m];
        next_cmp_rel[m] = cmp_rel[m];
        next_mode_reg[m] = mode_reg[m];
        case (mode_sel[m])
          CNTARR_TOGGLE: begin
            if (match[m]) begin
              next_pin[m] = ~pin[m]; // [RULE_01]
            end
          end
          CNTARR_PWM: begin
            // Shared counter gives a common frequency; duty per module
            next_pin[m] = (counter[7:0] >= cmp_low[m]); // [RULE_03] [RULE_04] [RULE_05]
          end
          default: begin
            next_pin[m] = pin[m];
          end
        endcase
        if (wr_en && mod_hit && (req.addr - 8'(mod_ofs)) == MODE_BASE_OFS) begin
          if (32'(mod_idx) == m) next_mode_reg[m] = req.wdata[7:0];
        end
        if (wr_en && mod_hit && (req.addr - 8'(mod_ofs)) == CMP_LOW_BASE_OFS) begin
          if (32'(mod_idx) == m) next_cmp_low[m] = req.wdata[7:0];
        end
        if (wr_en && mod_hit && (req.addr - 8'(mod_ofs)) == CMP_RELOAD_BASE_OFS) begin
          if (32'(mod_idx) == m) next_cmp_rel[m] = req.wdata[7:0];
        end
        // Reload at wrap beats a same-cycle software write: glitch-free duty
        if (wrap && mode_sel[m] == CNTARR_PWM) begin
          next_cmp_low[m] = cmp_rel[m]; // [RULE_06]
        end
      end
      always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
          mode_reg[m] <= MODE_RST;
          cmp_low[m] <= CMP_RST;
          cmp_rel[m] <= CMP_RST;
          pin[m] <= 1'b0;
        end else begin
          mode_reg[m] <= next_mode_reg[m];
          cmp_low[m] <= next_cmp_low[m];
          cmp_rel[m] <= next_cmp_rel[m];
          pin[m] <= next_pin[m];
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // Counter, control/status and interrupt state
  // ------------------------------------------------------------------
  always_comb begin
    next_counter = counter;
    next_run = run;
    next_ovf_flag = ovf_flag;
    next_ev_flag = ev_flag;
    next_cnt_mode = cnt_mode;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    if (run) begin
      next_counter = counter + 16'h0001; // [RULE_13]
    end
    // Software write first so hardware set wins in the same cycle
    if (wr_en && req.addr == CTRL_STATUS_OFS) begin
      next_run = req.wdata[CS_RUN_BIT]; // [RULE_13]
      next_ovf_flag = ovf_flag & req.wdata[CS_OVF_BIT];
      next_ev_flag = ev_flag & req.wdata[NUM_MODULES-1:0]; // [RULE_09]
    end
    if (wr_en && req.addr == COUNTER_OFS) next_counter = req.wdata[15:0];
    if (wr_en && req.addr == CNT_MODE_OFS) next_cnt_mode = req.wdata[7:0];
    if (wr_en && req.addr == IRQ_MASK_OFS) next_irq_mask = req.wdata[5:0];
    if (wr_en && req.addr == IRQ_STATUS_OFS) next_irq_stat = irq_stat & ~req.wdata[5:0];
    if (run && counter == 16'hFFFF) begin
      next_ovf_flag = 1'b1; // [RULE_12]
      next_irq_stat[IRQ_OVF_BIT] = 1'b1;
    end
    next_ev_flag = next_ev_flag | match; // [RULE_08]
    next_irq_stat[NUM_MODULES-1:0] = next_irq_stat[NUM_MODULES-1:0] | match;
  end

  // Control/status register file
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      counter <= COUNTER_RST;
      run <= CTRL_STATUS_RST[CS_RUN_BIT]; // [RULE_11]
      ovf_flag <= CTRL_STATUS_RST[CS_OVF_BIT];
      ev_flag <= '0;
      cnt_mode <= MODE_RST;
      irq_stat <= '0;
      irq_mask <= '0;
    end else begin
      counter <= next_counter;
      run <= next_run;
      ovf_flag <= next_ovf_flag;
      ev_flag <= next_ev_flag;
      cnt_mode <= next_cnt_mode;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
    end
  end

  // ------------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------------
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_slverr = 1'b0;
    if (req.addr == CTRL_STATUS_OFS) begin
      // Reserved bit reads zero
      next_prdata[7:0] = {ovf_flag, run, 1'b0, 5'(ev_flag)}; // [RULE_10]
    end else if (req.addr == COUNTER_OFS) begin
      next_prdata[15:0] = counter;
    end else if (req.addr == CNT_MODE_OFS) begin
      next_prdata[7:0] = cnt_mode;
    end else if (req.addr == IRQ_STATUS_OFS) begin
      next_prdata[5:0] = irq_stat;
    end else if (req.addr == IRQ_MASK_OFS) begin
      next_prdata[5:0] = irq_mask;
    end else if (mod_hit && (req.addr - mod_ofs) == MODE_BASE_OFS) begin
      next_prdata[7:0] = mode_reg[mod_idx];
    end else if (mod_hit && (req.addr - mod_ofs) == CMP_LOW_BASE_OFS) begin
      next_prdata[7:0] = cmp_low[mod_idx];
    end else if (mod_hit && (req.addr - mod_ofs) == CMP_RELOAD_BASE_OFS) begin
      next_prdata[7:0] = cmp_rel[mod_idx];
    end else begin
      next_slverr = 1'b1; // Unmapped address
    end
  end

  // Capture only in setup; holding it keeps read data still in access
  always_comb begin
    next_rd_word = PRDATA_O;
    next_rd_err = slverr_q;
    if (req.sel && !req.enable) begin
      next_rd_word = next_prdata;
      next_rd_err = next_slverr;
    end
  end

  // Read data registered at the setup edge, valid in access phase
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      PRDATA_O <= 32'h0000_0000;
      slverr_q <= 1'b0;
    end else begin
      PRDATA_O <= next_rd_word;
      slverr_q <= next_rd_err;
    end
  end
  assign PSLVERR_O = req.sel && req.enable && slverr_q;

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign MODULE_OUTPUT_PIN_O = pin;
  assign COUNTER_ARRAY_IRQ_O = |(ev_flag & flag_ie) ||
                               (ovf_flag && cnt_mode[COUNTER_MODE_REG_OVF_IE_BIT]); // [RULE_08] [RULE_12]
  assign IRQ_O = |(irq_stat & irq_mask);

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  // Module 1 is the one the bench puts in toggle mode
  sequence s_tog_match;
    mode_sel[1] == CNTARR_TOGGLE && match[1];
  endsequence
  // Match with its flag interrupt enabled
  sequence s_flag_irq_match;
    match[1] && mode_reg[1][MODE_FLAG_IE_BIT];
  endsequence
  AST_TOGGLE: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // [RULE_01]
    s_tog_match |=> (pin[1] != $past(pin[1])))
    else $error("toggle missed");
  // Without all three enables (and not PWM) the pin must hold
  AST_TOG_EN: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // [RULE_02]
    !(mode_reg[2][MODE_CMP_BIT] && mode_reg[2][MODE_TOG_BIT] && mode_reg[2][MODE_MATCH_BIT]) &&
    !(mode_reg[2][MODE_CMP_BIT] && mode_reg[2][MODE_PWM_BIT]) |=> $stable(pin[2]))
    else $error("pin moved without toggle enables");
  AST_PWM_LVL: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // [RULE_05]
    (mode_sel[1] == CNTARR_PWM && $stable(mode_sel[1])) |=>
      (pin[1] == ($past(counter[7:0]) >= $past(cmp_low[1]))))
    else $error("pwm level wrong");
  AST_RELOAD: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // [RULE_06]
    (wrap && mode_sel[2] == CNTARR_PWM) |=> (cmp_low[2] == $past(cmp_rel[2])))
    else $error("reload missed");
  // No comparator enable means neither PWM nor toggle may drive the pin
  AST_PWM_EN: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // [RULE_07]
    !mode_reg[3][MODE_CMP_BIT] |=> $stable(pin[3]))
    else $error("pin moved without comparator");
  AST_FLAG_SET: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // [RULE_08]
    match[1] |=> ev_flag[1])
    else $error("flag not set");
  AST_FLAG_IRQ: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // [RULE_08]
    s_flag_irq_match |=> COUNTER_ARRAY_IRQ_O)
    else $error("flag interrupt missing");
  AST_FLAG_HOLD: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // [RULE_09]
    (ev_flag[1] && !(wr_en && req.addr == CTRL_STATUS_OFS)) |=> ev_flag[1])
    else $error("flag lost");
  AST_OVF: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // [RULE_12]
    (run && counter == 16'hFFFF) |=> (ovf_flag && counter == 16'h0000))
    else $error("overflow missed");
  AST_STOP: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // [RULE_13]
    (!run && !(wr_en && req.addr == COUNTER_OFS)) |=> $stable(counter))
    else $error("counter moved while stopped");

endmodule : cntarr_top

// ---- verif/cntarr_top_tb.sv ----
`timescale 1ns/1ps
module cntarr_top_tb;
  import cntarr_pkg::*;

  // ------------------------------------------------------------
  // Signals and counters
  // ------------------------------------------------------------
  logic core_clk = 1'b0;
  logic rst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [4:0] pins;
  logic ca_irq;
  logic irq;
  logic [31:0] rd;
  logic err;
  logic [15:0] cnt;
  logic [7:0] low [5];
  logic p1;
  logic p2;
  int n_mismatch = 0;
  int n_tests = 0;
  int cycles = 0;
  int seed = 32'h892a;

  cntarr_top u_cntarr_top (
    .CORE_CLK_I(core_clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .MODULE_OUTPUT_PIN_O(pins),
    .COUNTER_ARRAY_IRQ_O(ca_irq), .IRQ_O(irq)
  );

  // 200 MHz clock
  always #2.5 core_clk = ~core_clk;

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // One APB transfer; request held until pready seen at an edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Wait ends at the first edge that sees pready high
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, what);
  endtask : rchk

  task set_mod(input int m, input logic [7:0] mode, input logic [7:0] lo, input logic [7:0] hi);
    apb(1'b1, MODE_BASE_OFS + 8'(4 * m), {24'h0, mode});
    apb(1'b1, CMP_LOW_BASE_OFS + 8'(4 * m), {24'h0, lo});
    apb(1'b1, CMP_RELOAD_BASE_OFS + 8'(4 * m), {24'h0, hi});
  endtask : set_mod

  function automatic logic pwm_exp(input logic [15:0] c, input logic [7:0] l);
    return c[7:0] >= l;
  endfunction : pwm_exp

  task done(input string name);
    $display("test %s done at %0t", name, $time);
  endtask : done

  task complete_run();
    $display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    rchk(CTRL_STATUS_OFS, 32'h00, "ctrl reset");
    apb(1'b1, CTRL_STATUS_OFS, 32'h20);
    rchk(CTRL_STATUS_OFS, 32'h00, "reserved bit");
    apb(1'b0, 8'hF0, 32'h0);
    chk(32'(err), 32'h1, "unmapped error");
    done("reset");
    // Random duty per module, counter held still so pins settle
    for (int k = 0; k < 8; k++) begin
      cnt = (k == 0) ? 16'h00FF : 16'($random(seed));
      for (int m = 0; m < 5; m++) begin
        low[m] = (k == 0 && m == 0) ? 8'hFF : (k == 0 && m == 1) ? 8'h00 : 8'($random(seed));
        set_mod(m, 8'h42, low[m], low[m]);
      end
      apb(1'b1, COUNTER_OFS, {16'h0, cnt});
      repeat (3) @(posedge core_clk);
      for (int m = 0; m < 5; m++) chk(32'(pins[m]), 32'(pwm_exp(cnt, low[m])), "pwm");
    end
    done("pwm");
    // Low byte wrap reloads low compare; run bit gates counting
    set_mod(0, 8'h42, 8'h10, 8'hC0);
    apb(1'b1, COUNTER_OFS, 32'h01FD);
    apb(1'b1, CTRL_STATUS_OFS, 32'hFF);
    apb(1'b1, CTRL_STATUS_OFS, 32'hBF);
    rchk(CMP_LOW_BASE_OFS, 32'hC0, "reload");
    apb(1'b0, COUNTER_OFS, 32'h0);
    cnt = rd[15:0];
    chk(32'(cnt > 16'h01FD), 32'h1, "counter ran");
    repeat (5) @(posedge core_clk);
    rchk(COUNTER_OFS, {16'h0, cnt}, "counter held");
    done("reload");
    // Toggle on match; match without toggle leaves pin alone
    for (int m = 0; m < 5; m++) set_mod(m, 8'h00, 8'h00, 8'h00);
    set_mod(1, 8'h4D, 8'h10, 8'h00);
    set_mod(2, 8'h48, 8'h10, 8'h00);
    apb(1'b1, COUNTER_OFS, 32'h0008);
    apb(1'b1, CTRL_STATUS_OFS, 32'h00);
    p1 = pins[1];
    p2 = pins[2];
    apb(1'b1, CTRL_STATUS_OFS, 32'h7F);
    repeat (20) @(posedge core_clk);
    apb(1'b1, CTRL_STATUS_OFS, 32'hBF);
    chk(32'(pins[1]), 32'(!p1), "toggle");
    chk(32'(pins[2]), 32'(p2), "no toggle");
    rchk(CTRL_STATUS_OFS, 32'h06, "match flags");
    chk(32'(ca_irq), 32'h1, "flag irq");
    apb(1'b1, CTRL_STATUS_OFS, 32'h02);
    repeat (4) @(posedge core_clk);
    rchk(CTRL_STATUS_OFS, 32'h02, "sw clear only");
    set_mod(1, 8'h4C, 8'h10, 8'h00);
    chk(32'(ca_irq), 32'h0, "flag irq off");
    done("toggle");
    // Overflow flag, its enable, and the status/mask pair
    set_mod(1, 8'h00, 8'h00, 8'h00);
    set_mod(2, 8'h00, 8'h00, 8'h00);
    apb(1'b1, CTRL_STATUS_OFS, 32'h00);
    apb(1'b1, IRQ_STATUS_OFS, 32'h3F);
    apb(1'b1, CNT_MODE_OFS, 32'h1);
    apb(1'b1, IRQ_MASK_OFS, 32'h20);
    apb(1'b1, COUNTER_OFS, 32'hFFFD);
    apb(1'b1, CTRL_STATUS_OFS, 32'hFF);
    apb(1'b1, CTRL_STATUS_OFS, 32'hBF);
    rchk(CTRL_STATUS_OFS, 32'h80, "overflow flag");
    chk(32'(ca_irq), 32'h1, "overflow irq");
    rchk(IRQ_STATUS_OFS, 32'h20, "irq status");
    chk(32'(irq), 32'h1, "irq unmasked");
    // Write lands at the edge the task returns on: look one edge later
    apb(1'b1, IRQ_MASK_OFS, 32'h00);
    @(posedge core_clk);
    chk(32'(irq), 32'h0, "irq masked");
    apb(1'b1, CNT_MODE_OFS, 32'h0);
    @(posedge core_clk);
    chk(32'(ca_irq), 32'h0, "overflow irq off");
    apb(1'b1, IRQ_MASK_OFS, 32'h20);
    apb(1'b1, IRQ_STATUS_OFS, 32'h20);
    @(posedge core_clk);
    chk(32'(irq), 32'h0, "irq cleared");
    done("overflow");
    // Second reset in mid-run
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    rchk(CTRL_STATUS_OFS, 32'h00, "ctrl re-reset");
    done("rereset");
    complete_run();
  end

endmodule : cntarr_top_tb
